/* bench/nvm_access_monitor.sv */
// Port checker for the nonvolatile access controller, bound to its top
`timescale 1ns/100ps
`default_nettype none
module nvm_access_monitor #(
    parameter int WRITE_SUB_TICKS = 4
) (
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic       clock_en,
    input wire logic       sfr_sector,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_write,
    input wire logic       sfr_read,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       sub_clock,
    input wire logic       done_flag_clear,
    input wire logic       nvm_write_done_flag,
    input wire logic       multi_function_request,
    input wire logic       busy
);
    default clocking mon_cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    logic       ctl_hit;
    logic       addr_hit;
    logic       data_hit;
    logic [7:0] busy_cnt;
    logic [7:0] next_busy_cnt;
    assign ctl_hit  = clock_en && sfr_sector && sfr_addr == 8'h40;
    assign addr_hit = clock_en && !sfr_sector && sfr_addr == 8'h46;
    assign data_hit = clock_en && !sfr_sector && sfr_addr == 8'h47;
    // Generous bound: each tick takes about eleven clocks in the bench
    always_comb next_busy_cnt = busy ? busy_cnt + 8'h01 : 8'h00;
    always_ff @(posedge clock) begin
        busy_cnt <= reset_n ? next_busy_cnt : 8'h00;
    end

    mfr_sets_flag_a: assert property (
        multi_function_request |-> nvm_write_done_flag)
        else $error("done pulse without flag");
    mfr_single_a: assert property (
        multi_function_request |=> !multi_function_request)
        else $error("done pulse longer than one cycle");
    flag_sticky_a: assert property (
        nvm_write_done_flag && !done_flag_clear |=> nvm_write_done_flag)
        else $error("done flag dropped by itself");
    flag_clear_a: assert property (
        clock_en && done_flag_clear
        |=> !nvm_write_done_flag || multi_function_request)
        else $error("done flag not cleared");
    mfr_at_end_a: assert property (
        multi_function_request |-> $fell(busy))
        else $error("done pulse outside write end");
    start_cause_a: assert property (
        $rose(busy) |-> $past(ctl_hit && sfr_write
                              && (sfr_wdata[2] || sfr_wdata[0])))
        else $error("cycle started without trigger");
    ctrl_upper_a: assert property (
        ctl_hit && sfr_read |=> sfr_rdata[7:4] == 4'h0)
        else $error("control upper bits not zero");
    addr_top_a: assert property (
        addr_hit && sfr_read |=> !sfr_rdata[7])
        else $error("address top bit not zero");
    unmapped_zero_a: assert property (
        clock_en && sfr_read && !ctl_hit && !addr_hit && !data_hit
        |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (
        !(clock_en && sfr_read) |=> $stable(sfr_rdata))
        else $error("read data changed without read");
    write_length_a: assert property (
        busy_cnt <= WRITE_SUB_TICKS * 16)
        else $error("access cycle too long");

    write_done_c: cover property (multi_function_request);
    read_done_c: cover property ($fell(busy) && !multi_function_request);
    flag_cleared_c: cover property ($fell(nvm_write_done_flag));
endmodule : nvm_access_monitor

bind nvm_access_ctrl nvm_access_monitor #(
    .WRITE_SUB_TICKS(WRITE_SUB_TICKS)
) mon (
    .clock(clock), .reset_n(reset_n), .clock_en(clock_en),
    .sfr_sector(sfr_sector), .sfr_addr(sfr_addr), .sfr_write(sfr_write),
    .sfr_read(sfr_read), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .sub_clock(sub_clock), .done_flag_clear(done_flag_clear),
    .nvm_write_done_flag(nvm_write_done_flag),
    .multi_function_request(multi_function_request), .busy(busy)
);
`default_nettype wire

/* bench/nvm_cpu_pointer.sv */
// CPU-side pointer model steering indirect accesses to the control register
`timescale 1ns/100ps
`default_nettype none
module nvm_cpu_pointer (
    input  wire logic       indirect,
    input  wire logic [7:0] pointer_one_high,
    input  wire logic [7:0] pointer_one_low,
    input  wire logic [7:0] direct_addr,
    output var  logic       sfr_sector,
    output var  logic [7:0] sfr_addr
);
    // Indirect port lands where the pointer pair points
    assign sfr_sector = indirect & pointer_one_high[0];
    assign sfr_addr   = indirect ? pointer_one_low : direct_addr;
endmodule : nvm_cpu_pointer
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the nonvolatile access controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int TICKS = 3;
    logic       clock = 0, reset_n = 0, sub_clock = 0, indirect = 0;
    logic       sfr_write = 0, sfr_read = 0, done_flag_clear = 0;
    logic       clock_en = 1;
    logic       sfr_sector, flag, mfr, busy;
    logic [7:0] sfr_addr, sfr_rdata, got;
    logic [7:0] sfr_wdata = 8'h00, direct_addr = 8'h00;
    logic [7:0] ptr_high = 8'h00, ptr_low = 8'h00;
    int         errors = 0, compares = 0, cycles = 0, pulses = 0;
    int         mem[128], addrs[$], a, d;

    always #20 clock = ~clock;
    // Sub clock runs from time zero, off phase from the system clock
    always #213 sub_clock = ~sub_clock;

    nvm_access_ctrl #(.WRITE_SUB_TICKS(TICKS)) DUT (
        .clock(clock), .reset_n(reset_n), .clock_en(clock_en),
        .sfr_sector(sfr_sector), .sfr_addr(sfr_addr),
        .sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sub_clock(sub_clock),
        .done_flag_clear(done_flag_clear), .nvm_write_done_flag(flag),
        .multi_function_request(mfr), .busy(busy));
    nvm_cpu_pointer cpu (
        .indirect(indirect), .pointer_one_high(ptr_high),
        .pointer_one_low(ptr_low), .direct_addr(direct_addr),
        .sfr_sector(sfr_sector), .sfr_addr(sfr_addr));

    task automatic conclude;
        $display("Counts: errors %0d, compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check

    // One register access; control goes through the pointer pair
    task automatic acc(input logic ind, input logic [7:0] off,
                       input logic wr, input logic [7:0] wd);
        @(negedge clock);
        indirect    = ind;
        ptr_high    = {7'h00, ind};
        ptr_low     = off;
        direct_addr = off;
        sfr_wdata   = wd;
        sfr_write   = wr;
        sfr_read    = !wr;
        @(negedge clock);
        sfr_write   = 1'b0;
        sfr_read    = 1'b0;
        got         = sfr_rdata;
    endtask : acc

    task automatic idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(negedge clock);
            n++;
        end
        check({7'h00, busy}, 8'h00);
    endtask : idle

    always @(posedge clock) begin
        cycles++;
        if (mfr === 1'b1) begin
            pulses++;
        end
        if (cycles == 5000) begin
            errors++;
            conclude();
        end
    end

    initial begin
        void'($urandom(32'hC63C));
        repeat (8) @(negedge clock);
        reset_n = 1'b1;
        acc(0, 8'h46, 0, 8'h00);
        check(got, 8'h00);
        acc(0, 8'h47, 0, 8'h00);
        check(got, 8'h00);
        acc(1, 8'h40, 0, 8'h00);
        check(got, 8'h00);
        acc(0, 8'h46, 1, 8'hFF);
        acc(0, 8'h46, 0, 8'h00);
        check(got, 8'h7F);
        acc(0, 8'h10, 0, 8'h00);
        check(got, 8'h00);
        // Deliberate refusal: all four bits in one write
        acc(1, 8'h40, 1, 8'h0F);
        acc(1, 8'h40, 0, 8'h00);
        check(got, 8'h0A);
        acc(1, 8'h40, 1, 8'h00);
        acc(1, 8'h40, 1, 8'h04);
        acc(1, 8'h40, 0, 8'h00);
        check(got, 8'h00);
        acc(1, 8'h40, 1, 8'h01);
        acc(1, 8'h40, 0, 8'h00);
        check(got, 8'h00);
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 0 : (i == 1) ? 127 : $urandom % 128;
            d = $urandom % 256;
            acc(0, 8'h46, 1, a[7:0]);
            acc(0, 8'h47, 1, d[7:0]);
            acc(1, 8'h40, 1, 8'h08);
            acc(1, 8'h40, 1, 8'h0C);
            acc(1, 8'h40, 0, 8'h00);
            check(got, 8'h0C);
            // Refused while busy, must not disturb the cycle
            acc(1, 8'h40, 1, 8'h00);
            idle();
            acc(1, 8'h40, 0, 8'h00);
            check(got, 8'h08);
            check({7'h00, flag}, 8'h01);
            @(negedge clock);
            done_flag_clear = 1'b1;
            @(negedge clock);
            done_flag_clear = 1'b0;
            check({7'h00, flag}, 8'h00);
            acc(0, 8'h47, 0, 8'h00);
            check(got, d[7:0]);
            mem[a] = d;
            addrs.push_back(a);
        end
        check(pulses[7:0], 8'h06);
        acc(1, 8'h40, 1, 8'h00);
        acc(0, 8'h46, 1, addrs[0][7:0]);
        acc(0, 8'h47, 1, 8'h5A);
        acc(1, 8'h40, 1, 8'h04);
        check({7'h00, busy}, 8'h00);
        foreach (addrs[i]) begin
            acc(0, 8'h46, 1, addrs[i][7:0]);
            acc(1, 8'h40, 1, 8'h02);
            acc(1, 8'h40, 1, 8'h03);
            idle();
            acc(1, 8'h40, 0, 8'h00);
            check(got, 8'h02);
            acc(0, 8'h47, 0, 8'h00);
            check(got, mem[addrs[i]][7:0]);
            acc(0, 8'h47, 0, 8'h00);
            check(got, mem[addrs[i]][7:0]);
        end
        acc(1, 8'h40, 1, 8'h00);
        acc(0, 8'h47, 1, 8'hA5);
        acc(1, 8'h40, 1, 8'h01);
        check({7'h00, busy}, 8'h00);
        acc(0, 8'h47, 0, 8'h00);
        check(got, 8'hA5);
        // Clock enable low must freeze a running read
        acc(1, 8'h40, 1, 8'h02);
        acc(1, 8'h40, 1, 8'h03);
        clock_en = 1'b0;
        repeat (5) @(negedge clock);
        check({7'h00, busy}, 8'h01);
        clock_en = 1'b1;
        idle();
        acc(0, 8'h47, 0, 8'h00);
        check(got, mem[addrs[addrs.size()-1]][7:0]);
        conclude();
    end
endmodule : testbench
`default_nettype wire

/* core/nvm_access_ctrl.sv */
// Access controller for the 128-byte nonvolatile data store
//
// Summary of operation
// - 128 bytes stored, addresses 00H to 7FH
// - Byte access only via address, data, control
// - Address register seven bits, top reads zero
// - Data register eight bits, cleared at reset
// - Control low four bits only, upper zero
// - No write while write enable is clear
// - Write trigger needs enable; cleared when done
// - No read while read enable is clear
// - Read trigger needs enable; cleared when done
// - Read byte lands in data register, stays
// - Enable then trigger on consecutive writes
// - Write end raises done and multi-function flags
// - Write enable cleared at reset
`timescale 1ns/100ps
`default_nettype none
module nvm_access_ctrl #(
    parameter int WRITE_SUB_TICKS = nvm_pkg::WRITE_SUB_TICKS
) (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       clock_en,
    input  wire logic       sfr_sector,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_write,
    input  wire logic       sfr_read,
    input  wire logic [7:0] sfr_wdata,
    output var  logic [7:0] sfr_rdata,
    input  wire logic       sub_clock,
    input  wire logic       done_flag_clear,
    output var  logic       nvm_write_done_flag,
    output var  logic       multi_function_request,
    output var  logic       busy
);
    localparam logic [nvm_pkg::CNT_W-1:0] WRITE_LAST =
        nvm_pkg::CNT_W'(WRITE_SUB_TICKS - 1);
    localparam logic [nvm_pkg::CNT_W-1:0] READ_LAST  =
        nvm_pkg::CNT_W'(nvm_pkg::READ_CYCLES - 1);

    // Register state
    logic [6:0]                 nvm_byte_address;
    logic [7:0]                 nvm_byte_data;
    logic                       write_enable_bit;
    logic                       write_trigger;
    logic                       read_enable_bit;
    logic                       read_trigger;
    nvm_pkg::nvm_state_t        state;
    logic [nvm_pkg::CNT_W-1:0]  count;
    logic [6:0]                 held_addr;
    logic [7:0]                 held_data;

    logic [6:0]                 next_byte_address;
    logic [7:0]                 next_byte_data;
    logic                       next_write_enable_bit;
    logic                       next_write_trigger;
    logic                       next_read_enable_bit;
    logic                       next_read_trigger;
    nvm_pkg::nvm_state_t        next_state;
    logic [nvm_pkg::CNT_W-1:0]  next_count;
    logic [6:0]                 next_held_addr;
    logic [7:0]                 next_held_data;
    logic [7:0]                 next_sfr_rdata;
    logic                       next_done_flag;
    logic                       next_mf_request;
    logic                       next_busy;

    logic                       sel_ctrl;
    logic                       sel_addr;
    logic                       sel_data;
    logic                       write_finish;
    logic                       read_finish;
    logic                       sub_tick;
    logic [7:0]                 ctrl_view;
    logic                       ctrl_write;
    logic                       start_write;
    logic                       start_read;

    nvm_store_if store_bus ();

    nvm_pin_sync u_sub_sync (
        .clock    (clock),
        .reset_n  (reset_n),
        .clock_en (clock_en),
        .pin      (sub_clock),
        .rise     (sub_tick)
    );

    nvm_byte_store #(
        .DEPTH (nvm_pkg::DEPTH)
    ) u_store (
        .clock    (clock),
        .reset_n  (reset_n),
        .clock_en (clock_en),
        .bus      (store_bus.store)
    );

    // Storage is never mapped; only these three registers reach it
    assign sel_ctrl = (sfr_sector == nvm_pkg::CTRL_SECTOR)
                   && (sfr_addr == nvm_pkg::CTRL_OFFSET);
    assign sel_addr = (sfr_sector == nvm_pkg::DATA_SECTOR)
                   && (sfr_addr == nvm_pkg::ADDR_OFFSET);
    assign sel_data = (sfr_sector == nvm_pkg::DATA_SECTOR)
                   && (sfr_addr == nvm_pkg::DATA_OFFSET);

    // Write length counted on synchronised sub clock edges
    assign write_finish = (state == nvm_pkg::NVM_WRITE) && sub_tick
                       && (count == WRITE_LAST);
    assign read_finish  = (state == nvm_pkg::NVM_READ)
                       && (count == READ_LAST);

    // Address taken from the register for reads, latched copy for writes
    assign store_bus.addr  = (state == nvm_pkg::NVM_WRITE) ? held_addr
                                                           : nvm_byte_address;
    assign store_bus.wdata = held_data;
    assign store_bus.we    = write_finish;
    assign store_bus.re    = (state == nvm_pkg::NVM_READ);

    assign ctrl_view = {4'h0, write_enable_bit, write_trigger,
                        read_enable_bit, read_trigger};

    // Control writes count only while idle; busy drops them, none queued
    assign ctrl_write  = sfr_write && sel_ctrl
                      && (state == nvm_pkg::NVM_IDLE);
    // Trigger looks at the enable as it stood before this write,
    // so enable and trigger in one write start a cycle only if the enable was already set
    assign start_write = ctrl_write && sfr_wdata[nvm_pkg::WR_BIT]
                      && write_enable_bit;
    // Write wins when both triggers qualify
    assign start_read  = ctrl_write && !start_write
                      && sfr_wdata[nvm_pkg::RD_BIT]
                      && read_enable_bit;

    // Register group: address, data and control bits
    always_comb begin
        next_byte_address     = nvm_byte_address;
        next_byte_data        = nvm_byte_data;
        next_write_enable_bit = write_enable_bit;
        next_write_trigger    = write_trigger;
        next_read_enable_bit  = read_enable_bit;
        next_read_trigger     = read_trigger;

        if (sfr_write && sel_addr) begin
            next_byte_address = sfr_wdata[6:0];
        end
        if (sfr_write && sel_data) begin
            next_byte_data = sfr_wdata;
        end

        // Enables move only on an accepted control write
        if (ctrl_write) begin
            next_write_enable_bit = sfr_wdata[nvm_pkg::WRITE_ENABLE_BIT_BIT];
            next_read_enable_bit  = sfr_wdata[nvm_pkg::READ_ENABLE_BIT_BIT];
        end
        if (start_write) begin
            next_write_trigger = 1'b1;
        end
        // Hardware clears each trigger at the end of its own cycle
        if (write_finish) begin
            next_write_trigger = 1'b0;
        end
        if (start_read) begin
            next_read_trigger = 1'b1;
        end

        if (read_finish) begin
            // Fetched byte wins over a data write in the same cycle
            next_byte_data    = store_bus.rdata;
            next_read_trigger = 1'b0;
        end
    end

    // Access engine: state, cycle count and latched write operands
    always_comb begin
        next_state     = state;
        next_count     = count;
        next_held_addr = held_addr;
        next_held_data = held_data;

        unique case (state)
            nvm_pkg::NVM_IDLE: begin
                if (start_write) begin
                    next_state     = nvm_pkg::NVM_WRITE;
                    next_count     = '0;
                    // Operands latched so the registers may change freely
                    next_held_addr = nvm_byte_address;
                    next_held_data = nvm_byte_data;
                end else if (start_read) begin
                    next_state = nvm_pkg::NVM_READ;
                    next_count = '0;
                end
            end
            nvm_pkg::NVM_READ: begin
                // Two-cycle fetch: address out, then byte captured
                if (read_finish) begin
                    next_state = nvm_pkg::NVM_IDLE;
                    next_count = '0;
                end else begin
                    next_count = count + 1'b1;
                end
            end
            nvm_pkg::NVM_WRITE: begin
                // Control writes ignored while the cell is programmed
                if (write_finish) begin
                    next_state = nvm_pkg::NVM_IDLE;
                    next_count = '0;
                end else if (sub_tick) begin
                    next_count = count + 1'b1;
                end
            end

            default: begin
                // Unused code falls back to idle
                next_state = nvm_pkg::NVM_IDLE;
                next_count = '0;
            end
        endcase
    end

    // Read port and flags; a set in the cycle of a clear is kept
    always_comb begin
        next_sfr_rdata = sfr_rdata;
        if (sfr_read) begin
            if (sel_addr) begin
                next_sfr_rdata = {1'b0, nvm_byte_address};
            end else if (sel_data) begin
                next_sfr_rdata = nvm_byte_data;
            end else if (sel_ctrl) begin
                next_sfr_rdata = ctrl_view;
            end else begin
                next_sfr_rdata = 8'h00;
            end
        end
        next_done_flag = nvm_write_done_flag;
        if (done_flag_clear) begin
            next_done_flag = 1'b0;
        end
        if (write_finish) begin
            next_done_flag = 1'b1;
        end
        next_mf_request = write_finish;
        next_busy       = (next_state != nvm_pkg::NVM_IDLE);
    end

    // Register group flops
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            nvm_byte_address <= nvm_pkg::ADDR_RESET;
            nvm_byte_data    <= nvm_pkg::DATA_RESET;
            write_enable_bit <= nvm_pkg::CTRL_BIT_RESET;
            write_trigger    <= nvm_pkg::CTRL_BIT_RESET;
            read_enable_bit  <= nvm_pkg::CTRL_BIT_RESET;
            read_trigger     <= nvm_pkg::CTRL_BIT_RESET;
        end else if (clock_en) begin
            nvm_byte_address <= next_byte_address;
            nvm_byte_data    <= next_byte_data;
            write_enable_bit <= next_write_enable_bit;
            write_trigger    <= next_write_trigger;
            read_enable_bit  <= next_read_enable_bit;
            read_trigger     <= next_read_trigger;
        end
    end

    // Access engine flops
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state     <= nvm_pkg::NVM_IDLE;
            count     <= '0;
            held_addr <= nvm_pkg::ADDR_RESET;
            held_data <= nvm_pkg::DATA_RESET;
        end else if (clock_en) begin
            state     <= next_state;
            count     <= next_count;
            held_addr <= next_held_addr;
            held_data <= next_held_data;
        end
    end

    // Output flops: every top output leaves from here
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sfr_rdata              <= nvm_pkg::RDATA_RESET;
            nvm_write_done_flag    <= 1'b0;
            multi_function_request <= 1'b0;
            busy                   <= 1'b0;
        end else if (clock_en) begin
            sfr_rdata              <= next_sfr_rdata;
            nvm_write_done_flag    <= next_done_flag;
            multi_function_request <= next_mf_request;
            busy                   <= next_busy;
        end
    end
endmodule : nvm_access_ctrl
`default_nettype wire

/* core/nvm_byte_store.sv */
// Byte-wide nonvolatile storage array
`timescale 1ns/100ps
`default_nettype none
module nvm_byte_store #(
    parameter int DEPTH = nvm_pkg::DEPTH
) (
    input  wire logic  clock,
    input  wire logic  reset_n,
    input  wire logic  clock_en,
    nvm_store_if.store bus
);
    logic [7:0] cells [DEPTH];
    logic [7:0] rdata_q;
    logic [7:0] next_rdata;

    assign bus.rdata = rdata_q;

    always_comb begin
        next_rdata = bus.re ? cells[bus.addr] : rdata_q;
    end

    // Cells keep their content over reset, as nonvolatile storage does
    always_ff @(posedge clock) begin
        if (clock_en && bus.we) begin
            cells[bus.addr] <= bus.wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rdata_q <= nvm_pkg::DATA_RESET;
        end else if (clock_en) begin
            rdata_q <= next_rdata;
        end
    end
endmodule : nvm_byte_store
`default_nettype wire

/* core/nvm_pin_sync.sv */
// Three-stage input synchroniser with agreement filter and rise pulse
`timescale 1ns/100ps
`default_nettype none
module nvm_pin_sync (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic clock_en,
    input  wire logic pin,
    output var  logic rise
);
    logic [2:0] stage;
    logic       level;
    logic [2:0] next_stage;
    logic       next_level;
    logic       next_rise;

    // Level only moves when the two settled stages agree
    always_comb begin
        next_stage = {stage[1:0], pin};
        next_level = (stage[1] == stage[2]) ? stage[2] : level;
        next_rise  = next_level & ~level;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            stage <= 3'h0;
            level <= 1'b0;
            rise  <= 1'b0;
        end else if (clock_en) begin
            stage <= next_stage;
            level <= next_level;
            rise  <= next_rise;
        end
    end
endmodule : nvm_pin_sync
`default_nettype wire

/* core/nvm_pkg.sv */
// Constants and types of the nonvolatile byte access controller
package nvm_pkg;

    // Storage geometry
    localparam int          ADDR_W            = 7;
    localparam int          DEPTH             = 128;

    // Register placement: sector select plus offset within the sector
    localparam logic        CTRL_SECTOR       = 1'b1;
    localparam logic [7:0]  CTRL_OFFSET       = 8'h40;
    localparam logic        DATA_SECTOR       = 1'b0;
    localparam logic [7:0]  ADDR_OFFSET       = 8'h46;
    localparam logic [7:0]  DATA_OFFSET       = 8'h47;

    // Control register fields
    localparam int          WRITE_ENABLE_BIT_BIT          = 3;
    localparam int          WR_BIT            = 2;
    localparam int          READ_ENABLE_BIT_BIT          = 1;
    localparam int          RD_BIT            = 0;

    // Values after reset
    localparam logic [6:0]  ADDR_RESET        = 7'h00;
    localparam logic [7:0]  DATA_RESET        = 8'h00;
    localparam logic        CTRL_BIT_RESET    = 1'b0;
    localparam logic [7:0]  RDATA_RESET       = 8'h00;

    // Timing
    localparam int          CLOCK_HZ          = 25_000_000;
    localparam int          CLOCK_PERIOD_NS   = 1_000_000_000 / CLOCK_HZ;
    localparam int          READ_TIME_NS      = 80;
    localparam int          READ_CYCLES_RAW   =
        (READ_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int          READ_CYCLES       =
        (READ_CYCLES_RAW < 2) ? 2 : READ_CYCLES_RAW;
    localparam int          WRITE_SUB_TICKS   = 64;
    localparam int          CNT_W             = 16;

    typedef enum logic [1:0] {
        NVM_IDLE,
        NVM_READ,
        NVM_WRITE
    } nvm_state_t;

endpackage : nvm_pkg

/* core/nvm_store_if.sv */
// Port bundle between the controller and the byte store
`timescale 1ns/100ps
`default_nettype none
interface nvm_store_if;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
    logic [7:0] rdata;

    modport ctl   (output addr, output wdata, output we, output re,
                   input rdata);
    modport store (input addr, input wdata, input we, input re,
                   output rdata);
endinterface : nvm_store_if
`default_nettype wire
